/* File: tw_pkg.sv */
// Shared constants and types for the 8-bit waveform timer.
// Assumes a plain single-clock register port with 8-bit address and data.
package tw_pkg;
   localparam int TW_DW = 8;
   localparam int TW_AW = 8;
   localparam int TW_PW = 10;

   // Register offsets
   localparam logic [TW_AW-1:0] TW_OFS_IRQ_MASK = 8'h70;
   localparam logic [TW_AW-1:0] TW_OFS_TIMER_CONTROL = 8'hB0;
   localparam logic [TW_AW-1:0] TW_OFS_COUNTER_VALUE = 8'hB2;
   localparam logic [TW_AW-1:0] TW_OFS_COMPARE_VALUE = 8'hB3;
   localparam logic [TW_AW-1:0] TW_OFS_IRQ_FLAGS = 8'h37;
   localparam logic [TW_AW-1:0] TW_OFS_CLOCK_SOURCE = 8'hB6;

   // Field positions
   localparam int TW_CTL_FORCE = 7;
   localparam int TW_CTL_WAVE_HI = 6;
   localparam int TW_CTL_COM_HI = 5;
   localparam int TW_CTL_COM_LO = 4;
   localparam int TW_CTL_WAVE_LO = 3;
   localparam int TW_CTL_CS_HI = 2;
   localparam int TW_CTL_CS_LO = 0;
   localparam int TW_IRQ_CMP = 1;
   localparam int TW_IRQ_OVF = 0;
   localparam int TW_SRC_ASYNC = 3;

   // Reset values
   localparam logic [TW_DW-1:0] TW_RST_CONTROL = 8'h00;
   localparam logic [TW_DW-1:0] TW_RST_COUNTER = 8'h00;
   localparam logic [TW_DW-1:0] TW_RST_COMPARE = 8'h00;
   localparam logic [1:0] TW_RST_MASK = 2'h0;
   localparam logic [1:0] TW_RST_FLAGS = 2'h0;

   localparam logic [TW_DW-1:0] TW_TOP_MAX = 8'hFF;
   localparam logic [TW_DW-1:0] TW_BOTTOM = 8'h00;

   // Waveform modes
   localparam logic [1:0] TW_WAVE_NORMAL = 2'h0;
   localparam logic [1:0] TW_WAVE_PHASE = 2'h1;
   localparam logic [1:0] TW_WAVE_CTC = 2'h2;
   localparam logic [1:0] TW_WAVE_FAST = 2'h3;

   // Compare output modes
   localparam logic [1:0] TW_COM_OFF = 2'h0;
   localparam logic [1:0] TW_COM_TOGGLE = 2'h1;
   localparam logic [1:0] TW_COM_CLEAR = 2'h2;
   localparam logic [1:0] TW_COM_SET = 2'h3;

   // Clock select codes
   localparam logic [2:0] TW_CS_STOP = 3'h0;
   localparam logic [2:0] TW_CS_DIRECT = 3'h1;

   typedef enum logic {TW_UP, TW_DOWN} tw_dir_type;
endpackage

/* File: tw_prescaler.sv */
// Prescaler for the waveform timer: turns source ticks into timer ticks.
// Assumes source_tick is a one-cycle pulse in the sys_clk domain.
`timescale 1ns/10ps
module tw_prescaler
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // Source and selection
   input wire logic source_tick,
   input wire logic [2:0] clock_sel,
   // Result
   output logic timer_tick
);
   import tw_pkg::*;

   typedef struct packed
   {
      logic [TW_PW-1:0] count;
   } tw_pre_type;

   tw_pre_type s;
   tw_pre_type next_s;

   // Shared counter, so taps stay in phase like a real ripple prescaler
   function automatic logic [TW_PW-1:0] tw_div_mask(input logic [2:0] sel);
      case (sel)
         3'h2: tw_div_mask = 10'h007;
         3'h3: tw_div_mask = 10'h01F;
         3'h4: tw_div_mask = 10'h03F;
         3'h5: tw_div_mask = 10'h07F;
         3'h6: tw_div_mask = 10'h0FF;
         default: tw_div_mask = 10'h3FF;
      endcase
   endfunction

   always_comb
   begin
      next_s = s;
      if (source_tick)
         next_s.count = s.count + 10'h001;
      timer_tick = 1'b0;
      if (clock_sel == TW_CS_DIRECT)
         timer_tick = source_tick;
      else if (clock_sel != TW_CS_STOP)
         timer_tick = source_tick && ((s.count & tw_div_mask(clock_sel)) == tw_div_mask(clock_sel));
   end

   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
         s <= '0;
      else
         s <= next_s;
   end
endmodule // tw_prescaler

/* File: tw_timer.sv */
// Top of the 8-bit waveform timer with one compare channel and its registers.
// Assumes a single-cycle register port, read data one cycle after the read strobe.
//
// The implementer's own choice: the strobed register port.
`timescale 1ns/10ps
module tw_timer
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // Register port
   input wire logic [tw_pkg::TW_AW-1:0] reg_addr,
   input wire logic [tw_pkg::TW_DW-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [tw_pkg::TW_DW-1:0] reg_rdata,
   // External oscillator, synchronous slow square wave
   input wire logic ext_osc_clk,
   // Core interrupt handshake
   input wire logic global_irq_enable,
   input wire logic compare_vector_ack,
   input wire logic overflow_vector_ack,
   output logic compare_irq_req,
   output logic overflow_irq_req,
   // Compare output pin
   output logic compare_out_pin,
   output logic compare_out_override
);
   import tw_pkg::*;

   typedef struct packed
   {
      logic [TW_DW-1:0] control;
      logic [TW_DW-1:0] counter;
      logic [TW_DW-1:0] compare_buf;
      logic [TW_DW-1:0] compare_active;
      logic [1:0] mask;
      logic [1:0] flags;
      logic async_sel;
      logic ext_prev;
      logic match_block;
      tw_dir_type dir;
      logic pin;
      logic override;
      logic cmp_req;
      logic ovf_req;
      logic [TW_DW-1:0] rdata;
   } tw_state_type;

   tw_state_type s;
   tw_state_type next_s;

   logic source_tick;
   logic timer_tick;
   logic [1:0] wave;
   logic [1:0] com;
   logic [1:0] wr_com;
   logic is_pwm;
   logic wr_pwm;
   logic [TW_DW-1:0] top;
   logic at_top;
   logic hit;
   logic special;
   logic wr_ctl;
   logic wr_cnt;
   logic wr_cmp;

   // Level after a non-PWM match
   function automatic logic tw_match_level(input logic [1:0] mode, input logic cur);
      case (mode)
         TW_COM_TOGGLE: tw_match_level = !cur;
         TW_COM_CLEAR: tw_match_level = 1'b0;
         TW_COM_SET: tw_match_level = 1'b1;
         default: tw_match_level = cur;
      endcase
   endfunction

   // Level after a PWM match while counting up; down is the inverse
   function automatic logic tw_pwm_level(input logic [1:0] mode, input logic up, input logic cur);
      case (mode)
         TW_COM_CLEAR: tw_pwm_level = !up;
         TW_COM_SET: tw_pwm_level = up;
         default: tw_pwm_level = cur;
      endcase
   endfunction

   function automatic logic tw_mode_is_pwm(input logic [1:0] mode);
      tw_mode_is_pwm = (mode == TW_WAVE_PHASE) || (mode == TW_WAVE_FAST);
   endfunction

   // Oscillator edge taken as one source tick
   assign source_tick = s.async_sel ? (ext_osc_clk && !s.ext_prev) : 1'b1;

   tw_prescaler u_prescaler
   (
      .sys_clk(sys_clk),
      .rst(rst),
      .source_tick(source_tick),
      .clock_sel(s.control[TW_CTL_CS_HI:TW_CTL_CS_LO]),
      .timer_tick(timer_tick)
   );

   always_comb
   begin
      next_s = s;
      next_s.ext_prev = ext_osc_clk;

      wave = {s.control[TW_CTL_WAVE_HI], s.control[TW_CTL_WAVE_LO]};
      com = s.control[TW_CTL_COM_HI:TW_CTL_COM_LO];
      is_pwm = tw_mode_is_pwm(wave);
      wr_com = reg_wdata[TW_CTL_COM_HI:TW_CTL_COM_LO];
      wr_pwm = tw_mode_is_pwm({reg_wdata[TW_CTL_WAVE_HI], reg_wdata[TW_CTL_WAVE_LO]});
      top = (wave == TW_WAVE_CTC) ? s.compare_active : TW_TOP_MAX;
      at_top = (s.counter == top);
      special = is_pwm && com[1] && (s.compare_active == top);
      hit = timer_tick && (s.counter == s.compare_active) && !s.match_block;

      wr_ctl = reg_wr && (reg_addr == TW_OFS_TIMER_CONTROL);
      wr_cnt = reg_wr && (reg_addr == TW_OFS_COUNTER_VALUE);
      wr_cmp = reg_wr && (reg_addr == TW_OFS_COMPARE_VALUE);

      // Clears first, so a same-cycle set below wins
      if (compare_vector_ack)
         next_s.flags[TW_IRQ_CMP] = 1'b0;
      if (overflow_vector_ack)
         next_s.flags[TW_IRQ_OVF] = 1'b0;
      if (reg_wr && (reg_addr == TW_OFS_IRQ_FLAGS))
      begin
         // Keeps a same-cycle vector clear of the other flag
         next_s.flags = next_s.flags & ~reg_wdata[1:0];
      end

      if (timer_tick)
      begin
         next_s.match_block = 1'b0;
         if (wave == TW_WAVE_PHASE)
         begin
            if (s.dir == TW_UP)
            begin
               if (at_top)
               begin
                  next_s.dir = TW_DOWN;
                  next_s.counter = s.counter - 8'h01;
                  next_s.compare_active = s.compare_buf;
               end
               else
               begin
                  next_s.counter = s.counter + 8'h01;
               end
            end
            else
            begin
               if (s.counter == TW_BOTTOM)
               begin
                  next_s.dir = TW_UP;
                  next_s.counter = s.counter + 8'h01;
                  next_s.flags[TW_IRQ_OVF] = 1'b1;
               end
               else
               begin
                  next_s.counter = s.counter - 8'h01;
               end
            end
         end
         else
         begin
            next_s.dir = TW_UP;
            next_s.counter = at_top ? TW_BOTTOM : s.counter + 8'h01;
            if ((wave == TW_WAVE_FAST) && at_top)
               next_s.compare_active = s.compare_buf;
            if (s.counter == TW_TOP_MAX)
               next_s.flags[TW_IRQ_OVF] = 1'b1;
         end

         if (hit)
            next_s.flags[TW_IRQ_CMP] = 1'b1;

         // Waveform unit
         unique case (wave)
            TW_WAVE_NORMAL, TW_WAVE_CTC:
            begin
               if (hit)
                  next_s.pin = tw_match_level(com, s.pin);
            end
            TW_WAVE_FAST:
            begin
               if (hit && !special)
                  next_s.pin = tw_pwm_level(com, 1'b1, s.pin);
               if (at_top)
                  next_s.pin = tw_pwm_level(com, 1'b0, s.pin);
            end
            TW_WAVE_PHASE:
            begin
               if (hit && !special)
                  next_s.pin = tw_pwm_level(com, s.dir == TW_UP, s.pin);
               if (at_top && special)
                  next_s.pin = tw_pwm_level(com, 1'b1, s.pin);
            end
         endcase
      end

      // Register writes, after the tick so software wins over counting
      if (wr_ctl)
      begin
         next_s.control = reg_wdata;
         next_s.control[TW_CTL_FORCE] = 1'b0;
         // Strobe acts with the newly written output mode; no flag, no clear
         if (reg_wdata[TW_CTL_FORCE] && !wr_pwm)
            next_s.pin = tw_match_level(wr_com, next_s.pin);
      end
      if (wr_cnt)
      begin
         next_s.counter = reg_wdata;
         next_s.match_block = 1'b1;
      end
      if (wr_cmp)
         next_s.compare_buf = reg_wdata;
      if (reg_wr && (reg_addr == TW_OFS_IRQ_MASK))
         next_s.mask = reg_wdata[1:0];
      if (reg_wr && (reg_addr == TW_OFS_CLOCK_SOURCE))
         next_s.async_sel = reg_wdata[TW_SRC_ASYNC];

      // Non-PWM modes use the written value at once
      if (!tw_mode_is_pwm({next_s.control[TW_CTL_WAVE_HI], next_s.control[TW_CTL_WAVE_LO]}))
         next_s.compare_active = next_s.compare_buf;

      next_s.override = |next_s.control[TW_CTL_COM_HI:TW_CTL_COM_LO];
      next_s.cmp_req = next_s.mask[TW_IRQ_CMP] && global_irq_enable && next_s.flags[TW_IRQ_CMP];
      next_s.ovf_req = next_s.mask[TW_IRQ_OVF] && global_irq_enable && next_s.flags[TW_IRQ_OVF];

      // Read data valid only in the cycle after the strobe
      next_s.rdata = 8'h00;
      if (reg_rd)
      begin
         unique case (reg_addr)
            TW_OFS_TIMER_CONTROL: next_s.rdata = s.control;
            TW_OFS_COUNTER_VALUE: next_s.rdata = s.counter;
            TW_OFS_COMPARE_VALUE: next_s.rdata = s.compare_buf;
            TW_OFS_IRQ_MASK: next_s.rdata = {6'h00, s.mask};
            TW_OFS_IRQ_FLAGS: next_s.rdata = {6'h00, s.flags};
            TW_OFS_CLOCK_SOURCE: next_s.rdata = 8'(s.async_sel) << TW_SRC_ASYNC;
            default: next_s.rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         s <= '0;
         s.control <= TW_RST_CONTROL;
         s.counter <= TW_RST_COUNTER;
         s.compare_buf <= TW_RST_COMPARE;
         s.compare_active <= TW_RST_COMPARE;
         s.mask <= TW_RST_MASK;
         s.flags <= TW_RST_FLAGS;
         s.dir <= TW_UP;
      end
      else
      begin
         s <= next_s;
      end
   end

   assign reg_rdata = s.rdata;
   assign compare_irq_req = s.cmp_req;
   assign overflow_irq_req = s.ovf_req;
   assign compare_out_pin = s.pin;
   assign compare_out_override = s.override;
endmodule // tw_timer

/* File: tw_timer_chk.sv */
// Checker for tw_timer: read port, pin actions and request gating.
// Sees only the top ports; bound to every tw_timer at the foot.
`timescale 1ns/10ps
module tw_timer_chk
   import tw_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // Register port
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   // Requests and pin
   input wire logic global_irq_enable,
   input wire logic compare_irq_req,
   input wire logic overflow_irq_req,
   input wire logic compare_out_pin,
   input wire logic compare_out_override
);
   logic wr_q;
   logic rd_q;
   logic [7:0] a_q;
   logic [7:0] d_q;
   logic [2:0] cs;
   logic [1:0] msk;
   logic ctl_wr;
   // Shadows of software writes, since the design's copies are hidden
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         wr_q <= 1'b0;
         rd_q <= 1'b0;
         a_q <= 8'h00;
         d_q <= 8'h00;
         cs <= 3'h0;
         msk <= 2'h0;
      end
      else
      begin
         wr_q <= reg_wr;
         rd_q <= reg_rd;
         a_q <= reg_addr;
         d_q <= reg_wdata;
         if (reg_wr && reg_addr == TW_OFS_TIMER_CONTROL)
            cs <= reg_wdata[2:0];
         if (reg_wr && reg_addr == TW_OFS_IRQ_MASK)
            msk <= reg_wdata[1:0];
      end
   end
   assign ctl_wr = wr_q && a_q == TW_OFS_TIMER_CONTROL;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   property p_rd_idle; !rd_q |-> reg_rdata == 8'h00; endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
   property p_force_rd; rd_q && a_q == TW_OFS_TIMER_CONTROL |-> !reg_rdata[7]; endproperty
   a_force_rd: assert property (p_force_rd) else $error("force bit read as one");
   property p_ovr; ctl_wr |-> compare_out_override == (d_q[5:4] != 2'h0); endproperty
   a_ovr: assert property (p_ovr) else $error("override wrong");
   property p_force; ctl_wr && d_q[7] && !d_q[3] && d_q[5] |-> compare_out_pin == d_q[4]; endproperty
   a_force: assert property (p_force) else $error("forced level wrong");
   property p_force_pwm;
      ctl_wr && d_q[7] && d_q[3] && d_q[2:0] == 3'h0 && $past(cs) == 3'h0 |-> $stable(compare_out_pin);
   endproperty
   a_force_pwm: assert property (p_force_pwm) else $error("force acted in pwm");
   property p_stop; cs == 3'h0 && !ctl_wr |-> $stable(compare_out_pin); endproperty
   a_stop: assert property (p_stop) else $error("pin moved while stopped");
   property p_creq; compare_irq_req |-> msk[1] && $past(global_irq_enable); endproperty
   a_creq: assert property (p_creq) else $error("compare request ungated");
   property p_oreq; overflow_irq_req |-> msk[0] && $past(global_irq_enable); endproperty
   a_oreq: assert property (p_oreq) else $error("overflow request ungated");
   c_force: cover property (ctl_wr && d_q[7]);
   c_creq: cover property (compare_irq_req);
   c_oreq: cover property (overflow_irq_req);
endmodule // tw_timer_chk

bind tw_timer tw_timer_chk i_tw_timer_chk (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .global_irq_enable(global_irq_enable), .compare_irq_req(compare_irq_req),
   .overflow_irq_req(overflow_irq_req), .compare_out_pin(compare_out_pin),
   .compare_out_override(compare_out_override));

/* File: tb.sv */
// Bench for tw_timer: registers, prescaler, flags, force and PWM duty.
// Drives all ports itself; the checker is bound from its own file.
`timescale 1ns/10ps
module tb;
   import tw_pkg::*;
   localparam logic [7:0] CTL = TW_OFS_TIMER_CONTROL;
   localparam logic [7:0] CNT = TW_OFS_COUNTER_VALUE;
   localparam logic [7:0] CMP = TW_OFS_COMPARE_VALUE;
   localparam logic [7:0] FLG = TW_OFS_IRQ_FLAGS;
   localparam logic [7:0] MSK = TW_OFS_IRQ_MASK;
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic ext_osc_clk = 1'b0;
   logic global_irq_enable = 1'b0;
   logic compare_vector_ack = 1'b0;
   logic overflow_vector_ack = 1'b0;
   logic [7:0] reg_rdata;
   logic compare_irq_req;
   logic overflow_irq_req;
   logic compare_out_pin;
   logic compare_out_override;
   logic [7:0] v;
   logic [7:0] c;
   int seed;
   int h;
   int cyc = 0;
   int n_mismatch = 0;
   int samples_checked = 0;
   logic [7:0] ofs [6] = '{MSK, CTL, CNT, CMP, FLG, 8'h01};
   logic [7:0] fv [4] = '{8'hB0, 8'hA0, 8'h90, 8'h90};
   logic [3:0] fx = 4'h5;
   logic [7:0] md [6] = '{8'h69, 8'h79, 8'h29, 8'h39, 8'h69, 8'h29};

   always #50 sys_clk = ~sys_clk;
   // Oscillator of 20 system cycles, edges only on falling sys_clk edges
   always #1000 ext_osc_clk = ~ext_osc_clk;

   tw_timer i_tw_timer (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ext_osc_clk(ext_osc_clk),
      .global_irq_enable(global_irq_enable), .compare_vector_ack(compare_vector_ack),
      .overflow_vector_ack(overflow_vector_ack), .compare_irq_req(compare_irq_req),
      .overflow_irq_req(overflow_irq_req), .compare_out_pin(compare_out_pin),
      .compare_out_override(compare_out_override));

   function automatic int div_of(input int s);
      int d [8] = '{0, 1, 8, 32, 64, 128, 256, 1024};
      return d[s];
   endfunction

   // Highs over one period: fast is 256 ticks, phase 510
   function automatic int duty(input int m, input int k);
      if (k == 255)
         return (m == 4) ? 256 : 0;
      case (m)
         0: return k + 1;
         1: return 255 - k;
         2: return 2 * k;
         default: return 510 - 2 * k;
      endcase
   endfunction

   task automatic summarize;
      $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   task automatic cv(input string n, input logic [7:0] e, input logic [7:0] g);
      samples_checked++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("ERROR %s exp %h got %h", n, e, g);
      end
   endtask

   task automatic cr(input string n, input int lo, input int hi, input logic [15:0] g);
      samples_checked++;
      if ($isunknown(g) || int'(g) < lo || int'(g) > hi)
      begin
         n_mismatch++;
         $display("ERROR %s exp %0d..%0d got %0d", n, lo, hi, g);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask

   // Plain read into v; data stand only in the cycle after the strobe
   task automatic rd(input logic [7:0] a);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      @(negedge sys_clk);
      v = reg_rdata;
   endtask

   task automatic rc(input logic [7:0] a, input logic [7:0] e, input string n);
      rd(a);
      cv(n, e, v);
   endtask

   // Runs from a start count for w cycles, then stops and reads the counter into v
   task automatic count_run(input logic [7:0] s, input logic [7:0] t, input int w);
      wr(CNT, s);
      wr(CTL, t);
      repeat (w) @(posedge sys_clk);
      wr(CTL, 8'h00);
      rd(CNT);
   endtask

   always @(posedge sys_clk)
   begin
      cyc++;
      if (cyc == 40000)
      begin
         n_mismatch++;
         summarize();
      end
   end

   initial
   begin
      seed = 24;
      repeat (12) @(posedge sys_clk);
      rst <= 1'b0;
      foreach (ofs[i])
         rc(ofs[i], 8'h00, "reset");
      c = 8'($random(seed));
      wr(CNT, c);
      repeat (20) @(posedge sys_clk);
      rc(CNT, c, "count_stop");
      wr(MSK, 8'hFF);
      rc(MSK, 8'h03, "mask");
      $display("test registers done");
      for (int s = 1; s < 8; s++)
      begin
         count_run(8'h00, 8'(s), 8 * div_of(s));
         cr("prescale", 7, (8 * div_of(s) + 2) / div_of(s) + 1, {8'h00, v});
      end
      wr(TW_OFS_CLOCK_SOURCE, 8'h08);
      count_run(8'h00, 8'h01, 2000);
      wr(TW_OFS_CLOCK_SOURCE, 8'h00);
      cr("async", 97, 103, {8'h00, v});
      $display("test prescaler done");
      wr(FLG, 8'h03);
      wr(CMP, 8'h80);
      global_irq_enable <= 1'b1;
      count_run(8'hFE, 8'h01, 4);
      cv("ovf_req", 8'h01, {7'h00, overflow_irq_req});
      cv("cmp_req", 8'h00, {7'h00, compare_irq_req});
      rc(FLG, 8'h01, "ovf_flag");
      @(posedge sys_clk);
      global_irq_enable <= 1'b0;
      repeat (2) @(negedge sys_clk);
      cv("ovf_gate", 8'h00, {7'h00, overflow_irq_req});
      @(posedge sys_clk);
      overflow_vector_ack <= 1'b1;
      @(posedge sys_clk);
      overflow_vector_ack <= 1'b0;
      rc(FLG, 8'h00, "ovf_ack");
      $display("test overflow done");
      @(posedge sys_clk);
      global_irq_enable <= 1'b1;
      c = 8'h10 + 8'($random(seed) & 31);
      wr(CMP, c);
      count_run(8'h00, 8'h41, 3 * c);
      cr("ctc_top", 0, c, {8'h00, v});
      cv("cmp_req", 8'h01, {7'h00, compare_irq_req});
      rc(FLG, 8'h02, "ctc_flags");
      wr(FLG, 8'h02);
      rc(FLG, 8'h00, "cmp_w1c");
      $display("test compare done");
      for (int i = 0; i < 4; i++)
      begin
         wr(CTL, fv[i]);
         @(negedge sys_clk);
         cv("force_pin", {7'h00, fx[i]}, {7'h00, compare_out_pin});
      end
      cv("override", 8'h01, {7'h00, compare_out_override});
      wr(CNT, 8'h32);
      wr(CMP, 8'h32);
      wr(CTL, 8'hC0);
      rc(CNT, 8'h32, "force_ctc");
      rc(FLG, 8'h00, "force_flag");
      rc(CTL, 8'h40, "force_read");
      wr(CTL, 8'hA8);
      $display("test force done");
      for (int m = 0; m < 6; m++)
      begin
         c = (m < 4) ? 8'h20 + 8'($random(seed) & 127) : 8'hFF;
         wr(CTL, md[m]);
         wr(CMP, c);
         repeat (1100) @(posedge sys_clk);
         h = 0;
         for (int k = 0; k < (md[m][6] ? 256 : 510); k++)
         begin
            @(negedge sys_clk);
            h += int'(compare_out_pin === 1'b1);
         end
         cr("pwm_duty", duty(m, c) - 2, duty(m, c) + 2, 16'(h));
      end
      wr(CTL, 8'h00);
      rc(FLG, 8'h03, "pwm_flags");
      @(posedge sys_clk);
      compare_vector_ack <= 1'b1;
      @(posedge sys_clk);
      compare_vector_ack <= 1'b0;
      rc(FLG, 8'h01, "cmp_ack");
      wr(FLG, 8'h01);
      rc(FLG, 8'h00, "ovf_w1c");
      $display("test pwm done");
      summarize();
   end
endmodule // tb
